/* File: rtl/hdc_device.sv */
// Haptic drive configuration registers and drive logic, device end
// Summary of operation
// - Mode 3: select bit picks PWM or analog
// - PWM input: amplitude from measured duty
// - Analog input: amplitude follows input level
// - Open drive fixed frequency, else auto-resonance
// - PWM open drive: commutation is PWM/128
// - Source PWM is 128 times resonant frequency
// - Other modes: frequency from open_drive_period
// - No open drive with analog input
// - Zero-cross window codes 100/200/300/390 us
// - Calibration window codes, reset code 2
// - Pick calibration long enough to settle
// - Fuse flag reads programmed state, resets 0
// - Launch copies 0x16..0x1A into fuse memory
// - Fuse memory programmed only once
// - Amplitude updates once or twice per cycle
// - Open period is field times 98.46 us
`timescale 1ns/1ps
module hdc_device #(
    parameter int CYCLES_PER_MS = 10000
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Link to host
    hdc_link_if.dev          link,
    // Engine side
    input  wire logic        res_phase,
    output logic [7:0]       amplitude_r,
    output logic             amp_update_r,
    output logic             drive_phase_r,
    output logic             resonance_track_en_r,
    output logic [12:0]      zc_min_cycles_r,
    output logic [23:0]      cal_min_cycles_r,
    output logic [23:0]      cal_max_cycles_r,
    output logic             fuse_programmed_r,
    output logic [39:0]      fuse_image_r
);
    import hdc_pkg::*;

    typedef enum logic [1:0] {
        HDC_IDLE = 2'b00,
        HDC_COPY = 2'b01,
        HDC_DONE = 2'b10
    } hdc_fuse_t;

    logic [7:0]  mode_r;
    logic [7:0]  dcfg_r;
    logic [1:0]  zc_r;
    logic [1:0]  cal_r;
    logic [6:0]  open_per_r;
    logic [7:0]  cfg_r [FUSE_BYTES];
    logic [7:0]  fuse_mem_r [FUSE_BYTES];
    hdc_fuse_t   fuse_st_r;
    logic [2:0]  fuse_idx_r;
    logic [4:0]  fuse_wait_r;
    logic        wr_en;
    logic        launch_req;
    logic        pin_mode;
    logic        analog_sel;
    logic        open_eff;
    logic        pin_prev_r;
    logic [7:0]  win_cnt_r;
    logic [7:0]  high_cnt_r;
    logic [7:0]  duty_r;
    logic [5:0]  edge_cnt_r;
    logic [13:0] acc_r;
    logic [6:0]  unit_cnt_r;
    logic        phase_prev_r;
    logic        phase_sel;

    // Decode of link writes
    assign wr_en      = link.req && link.we && !link.ack;
    assign launch_req = wr_en && link.addr == ADDR_TIMING && link.wdata[TFC_LAUNCH];
    assign pin_mode   = mode_r[2:0] == MODE_INPUT_PIN;
    assign analog_sel = dcfg_r[DCFG_SRC_SEL];
    assign open_eff   = dcfg_r[DCFG_OPEN] && !analog_sel;

    // Link answer: one ack cycle per request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link.ack   <= 1'b0;
            link.rdata <= 8'h00;
        end else begin
            link.ack   <= link.req && !link.ack;
            link.rdata <= 8'h00;
            if (link.addr == ADDR_MODE) begin
                link.rdata <= mode_r;
            end else if (link.addr >= ADDR_FUSE_FIRST && link.addr <= ADDR_FUSE_LAST) begin
                link.rdata <= cfg_r[3'(link.addr - ADDR_FUSE_FIRST)];
            end else if (link.addr == ADDR_DRIVE_CFG) begin
                link.rdata <= dcfg_r;
            end else if (link.addr == ADDR_TIMING) begin
                link.rdata <= {zc_r, cal_r, 1'b0, fuse_programmed_r, 1'b0,
                               fuse_st_r == HDC_COPY};
            end else if (link.addr == ADDR_OPEN_PER) begin
                link.rdata <= {1'b0, open_per_r};
            end
        end
    end

    // Register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_r     <= MODE_RESET;
            dcfg_r     <= DCFG_RESET;
            zc_r       <= ZC_RESET;
            cal_r      <= CAL_RESET;
            open_per_r <= OPEN_PER_RESET;
            for (int i = 0; i < FUSE_BYTES; i++) begin
                cfg_r[i] <= 8'h00;
            end
        end else if (wr_en) begin
            if (link.addr == ADDR_MODE) begin
                mode_r <= link.wdata;
            end
            if (link.addr >= ADDR_FUSE_FIRST && link.addr <= ADDR_FUSE_LAST) begin
                cfg_r[3'(link.addr - ADDR_FUSE_FIRST)] <= link.wdata;
            end
            if (link.addr == ADDR_DRIVE_CFG) begin
                dcfg_r <= link.wdata;
            end
            if (link.addr == ADDR_TIMING) begin
                zc_r  <= link.wdata[TFC_ZC_LSB +: 2];
                cal_r <= link.wdata[TFC_CAL_LSB +: 2];
            end
            if (link.addr == ADDR_OPEN_PER) begin
                open_per_r <= link.wdata[6:0];
            end
        end
    end

    // Fuse programming sequence, one byte per write slot
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fuse_st_r         <= HDC_IDLE;
            fuse_idx_r        <= 3'h0;
            fuse_wait_r       <= 5'h00;
            fuse_programmed_r <= 1'b0;
            for (int i = 0; i < FUSE_BYTES; i++) begin
                fuse_mem_r[i] <= 8'h00;
            end
        end else begin
            case (fuse_st_r)
                HDC_IDLE: begin
                    if (launch_req) begin
                        fuse_st_r   <= HDC_COPY;
                        fuse_idx_r  <= 3'h0;
                        fuse_wait_r <= 5'h00;
                    end
                end
                HDC_COPY: begin
                    if (fuse_wait_r == 5'(FUSE_WR_CYCLES - 1)) begin
                        fuse_mem_r[fuse_idx_r] <= cfg_r[fuse_idx_r];
                        fuse_wait_r            <= 5'h00;
                        if (fuse_idx_r == 3'(FUSE_BYTES - 1)) begin
                            fuse_st_r         <= HDC_DONE;
                            fuse_programmed_r <= 1'b1;
                        end else begin
                            fuse_idx_r <= fuse_idx_r + 3'h1;
                        end
                    end else begin
                        fuse_wait_r <= fuse_wait_r + 5'h01;
                    end
                end
                HDC_DONE: begin
                    fuse_st_r <= HDC_DONE;
                end
                default: begin
                    fuse_st_r <= HDC_IDLE;
                end
            endcase
        end
    end

    // Fuse contents shown to the engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fuse_image_r <= 40'h00_0000_0000;
        end else begin
            for (int i = 0; i < FUSE_BYTES; i++) begin
                fuse_image_r[8*i +: 8] <= fuse_mem_r[i];
            end
        end
    end

    // Duty measurement over a fixed sample window
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            win_cnt_r  <= 8'h00;
            high_cnt_r <= 8'h00;
            duty_r     <= 8'h00;
        end else if (win_cnt_r == 8'(DUTY_WINDOW - 1)) begin
            duty_r     <= high_cnt_r + {7'h00, link.trig_pin};
            win_cnt_r  <= 8'h00;
            high_cnt_r <= 8'h00;
        end else begin
            win_cnt_r  <= win_cnt_r + 8'h01;
            high_cnt_r <= high_cnt_r + {7'h00, link.trig_pin};
        end
    end

    // Open drive phase: PWM edges or internal period timer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_prev_r    <= 1'b0;
            edge_cnt_r    <= 6'h00;
            acc_r         <= 14'h0000;
            unit_cnt_r    <= 7'h00;
            drive_phase_r <= 1'b0;
        end else begin
            pin_prev_r <= link.trig_pin;
            if (!open_eff) begin
                edge_cnt_r <= 6'h00;
                acc_r      <= 14'h0000;
                unit_cnt_r <= 7'h00;
            end else if (pin_mode) begin
                if (link.trig_pin && !pin_prev_r) begin
                    edge_cnt_r <= edge_cnt_r + 6'h01;
                    if (edge_cnt_r == 6'(PWM_DIVIDE / 2 - 1)) begin
                        drive_phase_r <= !drive_phase_r;
                    end
                end
            end else if (open_per_r != 7'h00) begin
                // Two steps per clock: units count half periods
                if (acc_r + 14'(2 * CLK_PERIOD_CNS) >= 14'(OPEN_UNIT_CNS)) begin
                    acc_r <= acc_r + 14'(2 * CLK_PERIOD_CNS) - 14'(OPEN_UNIT_CNS);
                    if (unit_cnt_r + 7'h01 >= open_per_r) begin
                        unit_cnt_r    <= 7'h00;
                        drive_phase_r <= !drive_phase_r;
                    end else begin
                        unit_cnt_r <= unit_cnt_r + 7'h01;
                    end
                end else begin
                    acc_r <= acc_r + 14'(2 * CLK_PERIOD_CNS);
                end
            end
        end
    end

    // Amplitude update on drive cycle edges
    assign phase_sel = open_eff ? drive_phase_r : res_phase;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_prev_r <= 1'b0;
            amp_update_r <= 1'b0;
            amplitude_r  <= 8'h00;
        end else begin
            phase_prev_r <= phase_sel;
            amp_update_r <= 1'b0;
            if ((phase_sel && !phase_prev_r) ||
                (dcfg_r[DCFG_AMP_RATE] && !phase_sel && phase_prev_r)) begin
                amp_update_r <= 1'b1;
                if (!pin_mode) begin
                    amplitude_r <= 8'h00;
                end else if (analog_sel) begin
                    amplitude_r <= link.analog_level;
                end else begin
                    amplitude_r <= duty_r;
                end
            end
        end
    end

    // Timing field decode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resonance_track_en_r <= 1'b1;
            zc_min_cycles_r      <= 13'h0000;
            cal_min_cycles_r     <= 24'h00_0000;
            cal_max_cycles_r     <= 24'h00_0000;
        end else begin
            resonance_track_en_r <= !open_eff;
            zc_min_cycles_r      <= 13'(ZC_US[zc_r] * CLK_MHZ);
            cal_min_cycles_r     <= 24'(CAL_MIN_MS[cal_r] * CYCLES_PER_MS);
            cal_max_cycles_r     <= 24'(CAL_MAX_MS[cal_r] * CYCLES_PER_MS);
        end
    end
endmodule

/* File: pkg/hdc_pkg.sv */
// Shared constants for the haptic drive configuration block and its host end
package hdc_pkg;
    // Register offsets on the device link
    localparam logic [7:0] ADDR_MODE       = 8'h01;
    localparam logic [7:0] ADDR_FUSE_FIRST = 8'h16;
    localparam logic [7:0] ADDR_FUSE_LAST  = 8'h1A;
    localparam logic [7:0] ADDR_DRIVE_CFG  = 8'h1D;
    localparam logic [7:0] ADDR_TIMING     = 8'h1E;
    localparam logic [7:0] ADDR_OPEN_PER   = 8'h20;
    localparam int         FUSE_BYTES      = 5;
    // Field positions
    localparam int DCFG_AMP_RATE  = 2;
    localparam int DCFG_SRC_SEL   = 1;
    localparam int DCFG_OPEN      = 0;
    localparam int TFC_ZC_LSB     = 6;
    localparam int TFC_CAL_LSB    = 4;
    localparam int TFC_FUSE_FLAG  = 2;
    localparam int TFC_LAUNCH     = 0;
    localparam logic [2:0] MODE_INPUT_PIN = 3'h3;
    // Reset values
    localparam logic [7:0] MODE_RESET     = 8'h40;
    localparam logic [7:0] DCFG_RESET     = 8'hA0;
    localparam logic [1:0] ZC_RESET       = 2'h0;
    localparam logic [1:0] CAL_RESET      = 2'h2;
    localparam logic [6:0] OPEN_PER_RESET = 7'h00;
    // Timing
    localparam int CLK_MHZ        = 10;
    localparam int CLK_PERIOD_CNS = 10;    // 100 ns in hundredths of a us
    localparam int OPEN_UNIT_CNS  = 9846;  // 98.46 us
    localparam int PWM_DIVIDE     = 128;
    localparam int DUTY_WINDOW    = 255;
    localparam int FUSE_WR_CYCLES = 16;
    localparam int ZC_US  [4] = '{100, 200, 300, 390};
    localparam int CAL_MIN_MS [4] = '{150, 250, 500, 1000};
    localparam int CAL_MAX_MS [4] = '{350, 450, 700, 1200};
    // Host APB map
    localparam logic [7:0] APB_ADDR   = 8'h00;
    localparam logic [7:0] APB_WDATA  = 8'h04;
    localparam logic [7:0] APB_CTRL   = 8'h08;
    localparam logic [7:0] APB_STATUS = 8'h0C;
    localparam logic [7:0] APB_RES    = 8'h10;
    localparam logic [7:0] APB_DUTY   = 8'h14;
    localparam logic [7:0] APB_ANALOG = 8'h18;
endpackage

/* File: pkg/hdc_link_if.sv */
// Link between host end and haptic configuration device end
`timescale 1ns/1ps
interface hdc_link_if;
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    logic       trig_pin;
    logic [7:0] analog_level;

    modport dev  (input req, we, addr, wdata, trig_pin, analog_level, output rdata, ack);
    modport host (output req, we, addr, wdata, trig_pin, analog_level, input rdata, ack);
endinterface

/* File: rtl/hdc_host.sv */
// Host end: APB command registers, link master and input pin source
`timescale 1ns/1ps
module hdc_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to device
    hdc_link_if.host         link
);
    import hdc_pkg::*;

    logic [7:0]  addr_r;
    logic [7:0]  wdata_r;
    logic [7:0]  rdata_r;
    logic        busy_r;
    logic        refused_r;
    logic        launched_r;
    logic [15:0] res_r;
    logic [7:0]  duty_r;
    logic [15:0] pwm_cnt_r;
    logic [15:0] pwm_per;
    logic [23:0] pwm_high;
    logic        apb_wr;
    logic        bad_combo;
    logic        bad_launch;

    assign apb_wr     = psel && penable && pwrite;
    assign bad_combo  = addr_r == ADDR_DRIVE_CFG && wdata_r[DCFG_OPEN] && wdata_r[DCFG_SRC_SEL];
    assign bad_launch = addr_r == ADDR_TIMING && wdata_r[TFC_LAUNCH] && launched_r;
    assign pwm_per    = res_r >> $clog2(PWM_DIVIDE);
    assign pwm_high   = 24'(pwm_per * duty_r) >> 8;

    // APB access: answered in its first access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            case (paddr)
                APB_ADDR:   prdata <= {24'h00_0000, addr_r};
                APB_WDATA:  prdata <= {24'h00_0000, wdata_r};
                APB_STATUS: prdata <= {16'h0000, rdata_r, 5'h00, launched_r, refused_r, busy_r};
                APB_RES:    prdata <= {16'h0000, res_r};
                APB_DUTY:   prdata <= {24'h00_0000, duty_r};
                APB_ANALOG: prdata <= {24'h00_0000, link.analog_level};
                default:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Command registers and link transfers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_r            <= 8'h00;
            wdata_r           <= 8'h00;
            rdata_r           <= 8'h00;
            busy_r            <= 1'b0;
            refused_r         <= 1'b0;
            launched_r        <= 1'b0;
            res_r             <= 16'h0000;
            duty_r            <= 8'h00;
            link.analog_level <= 8'h00;
            link.req          <= 1'b0;
            link.we           <= 1'b0;
            link.addr         <= 8'h00;
            link.wdata        <= 8'h00;
        end else begin
            if (link.req && link.ack) begin
                link.req <= 1'b0;
                busy_r   <= 1'b0;
                rdata_r  <= link.rdata;
            end
            if (apb_wr && pready && !busy_r) begin
                case (paddr)
                    APB_ADDR:   addr_r            <= pwdata[7:0];
                    APB_WDATA:  wdata_r           <= pwdata[7:0];
                    APB_RES:    res_r             <= pwdata[15:0];
                    APB_DUTY:   duty_r            <= pwdata[7:0];
                    APB_ANALOG: link.analog_level <= pwdata[7:0];
                    APB_CTRL: begin
                        if (pwdata[0] && (bad_combo || bad_launch)) begin
                            refused_r <= 1'b1;
                        end else if (pwdata[0] || pwdata[1]) begin
                            refused_r  <= 1'b0;
                            busy_r     <= 1'b1;
                            link.req   <= 1'b1;
                            link.we    <= pwdata[0];
                            link.addr  <= addr_r;
                            link.wdata <= wdata_r;
                            if (pwdata[0] && addr_r == ADDR_TIMING && wdata_r[TFC_LAUNCH]) begin
                                launched_r <= 1'b1;
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // PWM source on the input pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwm_cnt_r     <= 16'h0000;
            link.trig_pin <= 1'b0;
        end else if (pwm_per == 16'h0000) begin
            pwm_cnt_r     <= 16'h0000;
            link.trig_pin <= 1'b0;
        end else begin
            pwm_cnt_r     <= (pwm_cnt_r + 16'h0001 >= pwm_per) ? 16'h0000 : pwm_cnt_r + 16'h0001;
            link.trig_pin <= {8'h00, pwm_cnt_r} < pwm_high;
        end
    end
endmodule

/* File: tb/hdc_link_props.sv */
// Link protocol and register readback checks between host and device ends
`timescale 1ns/1ps
module hdc_link_props (
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // Link signals
    input wire logic       req,
    input wire logic       we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack,
    input wire logic       trig_pin,
    input wire logic [7:0] analog_level
);
    import hdc_pkg::*;
    logic [2:0] dcfg_r;
    logic [3:0] tim_r;
    logic       flag_seen_r;
    logic       launched_r;
    logic       rd_ack;
    logic       wr_ack;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Completed transfers
    assign rd_ack = ack && !we;
    assign wr_ack = ack && we;
    // Shadow of written configuration fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dcfg_r <= DCFG_RESET[2:0];
            tim_r  <= {ZC_RESET, CAL_RESET};
        end else if (wr_ack && addr == ADDR_DRIVE_CFG) begin
            dcfg_r <= wdata[2:0];
        end else if (wr_ack && addr == ADDR_TIMING) begin
            tim_r <= wdata[7:4];
        end
    end
    // Fuse flag seen set, launch seen
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_seen_r <= 1'b0;
            launched_r  <= 1'b0;
        end else begin
            if (rd_ack && addr == ADDR_TIMING && rdata[TFC_FUSE_FLAG]) flag_seen_r <= 1'b1;
            if (wr_ack && addr == ADDR_TIMING && wdata[TFC_LAUNCH]) launched_r <= 1'b1;
        end
    end
    AST_ACK_PULSE: assert property (ack |=> !ack)
        else $error("link ack longer than one cycle");
    AST_ACK_NEEDS_REQ: assert property (ack |-> req)
        else $error("link ack without request");
    AST_ACK_AFTER_REQ: assert property ($rose(req) |=> ack)
        else $error("link ack late");
    AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
        else $error("link request changed before ack");
    AST_REQ_DROP: assert property (ack |=> !req)
        else $error("link request held after ack");
    AST_DCFG_READBACK: assert property (rd_ack && addr == ADDR_DRIVE_CFG |-> rdata[2:0] == dcfg_r)
        else $error("drive config readback wrong");
    AST_TIMING_READBACK: assert property (rd_ack && addr == ADDR_TIMING |-> rdata[7:4] == tim_r)
        else $error("timing fields readback wrong");
    AST_FLAG_STICKY: assert property (rd_ack && addr == ADDR_TIMING && flag_seen_r |-> rdata[2])
        else $error("fuse flag cleared");
    AST_NO_OPEN_ANALOG: assert property (req && we && addr == ADDR_DRIVE_CFG |-> wdata[1:0] != 2'h3)
        else $error("open drive with analog input sent");
    AST_ONE_LAUNCH: assert property (req && !ack && we && addr == ADDR_TIMING && launched_r |-> !wdata[0])
        else $error("second fuse launch sent");
    // Main scenarios reached
    cover property (wr_ack && addr == ADDR_TIMING && wdata[TFC_LAUNCH]);
    cover property (rd_ack && addr == ADDR_TIMING && rdata[TFC_FUSE_FLAG]);
    cover property (wr_ack && addr == ADDR_DRIVE_CFG && wdata[DCFG_OPEN]);
endmodule

/* File: tb/haptic_drive_config_regs_tb.sv */
// Self-checking bench for host and device ends of the haptic configuration link
`timescale 1ns/1ps
module haptic_drive_config_regs_tb;
    import hdc_pkg::*;
    localparam int CPM = 10;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        res_phase = 1'b0;
    logic [5:0]  ph_cnt = 6'h0;
    logic [7:0]  amplitude_r;
    logic        amp_update_r;
    logic        drive_phase_r;
    logic        resonance_track_en_r;
    logic        fuse_programmed_r;
    logic [12:0] zc_min_cycles_r;
    logic [23:0] cal_min_cycles_r;
    logic [23:0] cal_max_cycles_r;
    logic [39:0] fuse_image_r;
    logic [39:0] img;
    logic [31:0] seed = 32'hC936;
    logic [31:0] rd;
    logic [31:0] st;
    logic [1:0]  c;
    logic [7:0]  exp_q[$];
    int          errors = 0;
    int          samples_checked = 0;
    int          n;
    hdc_link_if link ();
    hdc_device #(.CYCLES_PER_MS(CPM)) u_hdc_device (.clk(clk), .sys_rst(sys_rst), .link(link),
        .res_phase(res_phase), .amplitude_r(amplitude_r), .amp_update_r(amp_update_r),
        .drive_phase_r(drive_phase_r), .resonance_track_en_r(resonance_track_en_r),
        .zc_min_cycles_r(zc_min_cycles_r), .cal_min_cycles_r(cal_min_cycles_r),
        .cal_max_cycles_r(cal_max_cycles_r), .fuse_programmed_r(fuse_programmed_r),
        .fuse_image_r(fuse_image_r));
    hdc_host u_hdc_host (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .link(link));
    hdc_link_props u_hdc_link_props (.clk(clk), .sys_rst(sys_rst), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
        .trig_pin(link.trig_pin), .analog_level(link.analog_level));
    // Clock and actuator phase, phase period 64 clocks
    always #50 clk = ~clk;
    always @(posedge clk) begin
        ph_cnt    <= ph_cnt + 6'h1;
        res_phase <= ph_cnt[5];
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic void xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
    endfunction
    // One APB transfer, request held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_idle();
        do apb(1'b0, APB_STATUS, 32'h0); while (rd[0] !== 1'b0);
        st = rd;
    endtask
    task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, APB_ADDR, {24'h0, a});
        apb(1'b1, APB_WDATA, {24'h0, d});
        apb(1'b1, APB_CTRL, 32'h1);
        wait_idle();
    endtask
    task automatic dev_rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        apb(1'b1, APB_ADDR, {24'h0, a});
        apb(1'b1, APB_CTRL, 32'h2);
        wait_idle();
    endtask
    // Cycles between two update pulses or two phase changes
    task automatic gap(input logic sel);
        logic p;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            p = drive_phase_r;
            do begin
                @(posedge clk);
                n++;
            end while ((sel ? amp_update_r : (drive_phase_r ^ p)) !== 1'b1 && n < 4000);
        end
    endtask
    // Read data monitor against oldest expectation
    always @(posedge clk) begin
        if (sys_rst === 1'b0 && link.ack === 1'b1 && link.we === 1'b0) begin
            if (exp_q.size() == 0) check(1, 0);
            else check(link.rdata, exp_q.pop_front());
        end
    end
    initial begin
        #5_000_000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        check(zc_min_cycles_r, ZC_US[0] * CLK_MHZ);
        check(cal_min_cycles_r, CAL_MIN_MS[2] * CPM);
        check(resonance_track_en_r, 1);
        check(fuse_programmed_r, 0);
        dev_rd(ADDR_TIMING, 8'h20);
        dev_rd(ADDR_DRIVE_CFG, 8'hA0);
        // Every window code with a random calibration code
        for (int i = 0; i < 4; i++) begin
            xs();
            c = seed[1:0];
            dev_wr(ADDR_TIMING, {i[1:0], c, 4'h0});
            repeat (2) @(posedge clk);
            check(zc_min_cycles_r, ZC_US[i] * CLK_MHZ);
            check(cal_min_cycles_r, CAL_MIN_MS[c] * CPM);
            check(cal_max_cycles_r, CAL_MAX_MS[c] * CPM);
            dev_rd(ADDR_TIMING, {i[1:0], c, 4'h0});
        end
        // Open drive from the period field, one unit of 98.46 us
        dev_wr(ADDR_OPEN_PER, 8'h01);
        dev_wr(ADDR_DRIVE_CFG, 8'hA1);
        check(resonance_track_en_r, 0);
        gap(1'b0);
        check(n == 492 || n == 493, 1);
        dev_wr(ADDR_DRIVE_CFG, 8'hA3);
        check(st[1], 1);
        dev_rd(ADDR_DRIVE_CFG, 8'hA1);
        // Input pin mode, PWM at 128 times the resonant rate
        dev_wr(ADDR_MODE, 8'h43);
        apb(1'b1, APB_DUTY, 32'h0000_0080);
        apb(1'b1, APB_RES, 32'h0000_0A00);
        gap(1'b0);
        check(n >= 1279 && n <= 1281, 1);
        // Analog amplitude and update rate
        xs();
        apb(1'b1, APB_ANALOG, {24'h0, seed[7:0]});
        dev_wr(ADDR_DRIVE_CFG, 8'hA2);
        check(resonance_track_en_r, 1);
        gap(1'b1);
        check(n, 64);
        check(amplitude_r, seed[7:0]);
        dev_wr(ADDR_DRIVE_CFG, 8'hA6);
        gap(1'b1);
        check(n, 32);
        // Amplitude from half duty PWM
        dev_wr(ADDR_DRIVE_CFG, 8'hA0);
        gap(1'b1);
        gap(1'b1);
        check(amplitude_r >= 8'h7B && amplitude_r <= 8'h84, 1);
        dev_wr(ADDR_MODE, 8'h40);
        gap(1'b1);
        check(amplitude_r, 0);
        // Fuse copy of the five configuration bytes
        for (int i = 0; i < FUSE_BYTES; i++) begin
            xs();
            img[8*i +: 8] = seed[7:0];
            dev_wr(ADDR_FUSE_FIRST + 8'(i), seed[7:0]);
        end
        dev_wr(ADDR_TIMING, 8'h21);
        check(fuse_programmed_r, 0);
        n = 0;
        while (fuse_programmed_r !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        check(fuse_image_r, img);
        dev_rd(ADDR_TIMING, 8'h24);
        dev_wr(ADDR_FUSE_FIRST, ~img[7:0]);
        dev_wr(ADDR_TIMING, 8'h21);
        check(st[1], 1);
        repeat (100) @(posedge clk);
        check(fuse_image_r, img);
        check(fuse_programmed_r, 1);
        dev_wr(ADDR_TIMING, 8'h20);
        dev_rd(ADDR_TIMING, 8'h24);
        print_verdict();
    end
endmodule
